// file: inc/tdpl_pkg.sv
// Summary of operation
// - two clock rises under held reset enter debug
// - debug mode: data pin bidirectional, clock pin input
// - sender drives on rise, receiver samples on fall
// - pins are general I/O only outside debug
// - command is 1-4 host bytes, one reply
// - all bytes shift most significant bit first
// - lock byte at info page 0; the bus writes it in or out of debug mode once the info page is selected and no erase is busy
// - protect size code maps top-down protected region
// - small flash supports only all/none codes
// - boot lock 0 protects page 0
// - debug lock 0 rejects all but three commands
// - status read reports the reported debug lock state, not the current lock byte
// - reported lock refreshes on cpu commands or reset
// - chip erase sets all lock bits to one
// - lock written as flash write, info page selected
// - lock byte: reserved, boot, size, debug lock
`default_nettype none
package tdpl_pkg;
  // debug command opcodes
  localparam logic [7:0] OPC_CHIP_ERASE = 8'h14;
  localparam logic [7:0] OPC_WR_CONFIG = 8'h1d;
  localparam logic [7:0] OPC_RD_CONFIG = 8'h24;
  localparam logic [7:0] OPC_GET_PC = 8'h28;
  localparam logic [7:0] OPC_READ_STATUS = 8'h34;
  localparam logic [7:0] OPC_SET_BREAK = 8'h3b;
  localparam logic [7:0] OPC_HALT = 8'h44;
  localparam logic [7:0] OPC_RESUME = 8'h4c;
  localparam logic [5:0] OPC_EXEC_PREFIX = 6'h15; // exec_injected_cmd, low 2 bits = extra bytes
  localparam logic [7:0] OPC_SINGLE_STEP = 8'h5c;
  localparam logic [5:0] OPC_STEP_REPL_PREFIX = 6'h19;
  localparam logic [7:0] OPC_IDENTITY_READ = 8'h68;
  // lock byte layout
  localparam int LOCK_DBG_BIT = 0;
  localparam int LOCK_SIZE_LSB = 1;
  localparam int LOCK_BOOT_BIT = 4;
  localparam logic [7:0] LOCK_RESERVED_MASK = 8'he0;
  localparam logic [7:0] LOCK_ERASED = 8'hff;
  localparam logic [10:0] LOCK_INFO_ADDR = 11'h000;
  // flash geometry
  localparam logic [15:0] FLASH_TOP = 16'h8000;
  localparam logic [15:0] PAGE0_LAST = 16'h03ff;
  localparam logic [2:0] SIZE_ALL = 3'h0;
  localparam logic [2:0] SIZE_NONE = 3'h7;
  // debug config and status bytes
  localparam int CFG_INFO_PAGE_BIT = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int STAT_ERASE_DONE_BIT = 7;
  localparam int STAT_DBG_LOCK_BIT = 2;
  // bus register map and status bits
  localparam logic [7:0] REG_LOCK = 8'h00;
  localparam logic [7:0] REG_CONFIG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int RS_DEBUG_MODE = 0;
  localparam int RS_ERASE_BUSY = 1;
  localparam int RS_LOCK_REP = 2;
  localparam int RS_INFO_SEL = 3;
  // timing
  localparam int ENTRY_EDGES = 2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [0:0] {LS_RX, LS_TX} tdpl_link_state_t;

  typedef struct packed {
    logic o;
    logic oe;
  } tdpl_pin_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] data;
  } tdpl_cmd_t;

  typedef struct packed {
    logic [2:0] clk_sync;
    logic [2:0] dat_sync;
    logic [2:0] rst_sync;
    logic clk_f;
    logic dat_f;
    logic rst_f;
    logic [1:0] entry_cnt;
    logic debug_mode;
    tdpl_link_state_t link;
    logic [3:0] bit_cnt;
    logic [1:0] byte_idx;
    logic [7:0] rx_shift;
    tdpl_cmd_t cmd;
    logic [7:0] tx_shift;
    logic tx_from_core;
    logic cmd_valid;
    logic [7:0] lock;
    logic lock_rep;
    logic refresh_pend;
    logic [7:0] cfg;
    logic erase_busy;
    logic [31:0] erase_cnt;
    tdpl_pin_t data_pin;
    tdpl_pin_t clock_pin;
    logic protected_q;
    logic ahb_wr;
    logic [7:0] ahb_addr;
    logic [31:0] rdata;
  } tdpl_state_t;

  // bytes protected from the top of flash for each size code
  function automatic logic [15:0] tdpl_size_bytes(input logic [2:0] code);
    case (code)
      3'h0: tdpl_size_bytes = 16'h8000;
      3'h1: tdpl_size_bytes = 16'h6000;
      3'h2: tdpl_size_bytes = 16'h4000;
      3'h3: tdpl_size_bytes = 16'h2000;
      3'h4: tdpl_size_bytes = 16'h1000;
      3'h5: tdpl_size_bytes = 16'h0800;
      3'h6: tdpl_size_bytes = 16'h0400;
      default: tdpl_size_bytes = 16'h0000;
    endcase
  endfunction
endpackage
`default_nettype wire

// file: verilog/tdpl_debug_port.sv
`default_nettype none
module tdpl_debug_port import tdpl_pkg::*; #(
  parameter int ERASE_CYCLES = 1024,
  parameter bit SMALL_FLASH = 1'b0,
  parameter logic [7:0] IDENT_BYTE = 8'h5a // arbitrary identity value
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // device pins
  input wire logic chip_reset_pin_n_in,
  input wire logic dbg_clock_pin_in,
  input wire logic dbg_data_pin_in,
  output logic dbg_data_pin_out,
  output logic dbg_data_pin_oe_out,
  output logic dbg_clock_pin_out,
  output logic dbg_clock_pin_oe_out,
  // general purpose use of the two pins
  input wire tdpl_pin_t gpio_data_pin_in,
  input wire tdpl_pin_t gpio_clock_pin_in,
  output logic debug_mode_out,
  // cpu-side command channel
  output logic core_cmd_valid_out,
  output tdpl_cmd_t core_cmd_out,
  input wire logic [7:0] core_resp_in,
  // flash write protection query
  input wire logic [14:0] flash_wr_addr_in,
  output logic flash_wr_protected_out,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out
);

  localparam logic [31:0] ERASE_LAST = 32'(ERASE_CYCLES - 1);

  tdpl_state_t q;
  tdpl_state_t d;

  // index of the last host byte in a command, from its opcode
  function automatic logic [1:0] cmd_last_idx(input logic [7:0] op);
    if (op == OPC_WR_CONFIG) begin
      cmd_last_idx = 2'd1;
    end else if (op == OPC_SET_BREAK) begin
      cmd_last_idx = 2'd3;
    end else if (op[7:2] == OPC_EXEC_PREFIX || op[7:2] == OPC_STEP_REPL_PREFIX) begin
      cmd_last_idx = op[1:0];
    end else begin
      cmd_last_idx = 2'd0;
    end
  endfunction

  // commands that halt, run or step the cpu and refresh the reported lock
  function automatic logic is_refresh(input logic [7:0] op);
    is_refresh = (op == OPC_HALT) || (op == OPC_RESUME) || (op == OPC_SINGLE_STEP) ||
      (op[7:2] == OPC_EXEC_PREFIX) || (op[7:2] == OPC_STEP_REPL_PREFIX);
  endfunction

  logic clk_stable;
  logic clk_rise;
  logic clk_fall;
  logic [7:0] rx_byte;
  logic [7:0] status_byte;
  logic [7:0] op;
  logic permitted;
  logic [2:0] size_code;
  logic [15:0] wr_addr;
  logic ahb_sel;

  // qualified edges of the filtered debug clock
  assign clk_stable = (q.clk_sync[1] == q.clk_sync[2]);
  assign clk_rise = clk_stable & q.clk_sync[2] & ~q.clk_f;
  assign clk_fall = clk_stable & ~q.clk_sync[2] & q.clk_f;
  assign rx_byte = {q.rx_shift[6:0], q.dat_f}; // msb arrived first
  assign op = (q.byte_idx == 2'd0) ? rx_byte : q.cmd.opcode;

  // status byte: erase progress and the reported lock
  always_comb begin
    status_byte = 8'h00;
    status_byte[STAT_ERASE_DONE_BIT] = ~q.erase_busy;
    status_byte[STAT_DBG_LOCK_BIT] = q.lock_rep;
  end

  // locked device runs only erase, status and identity
  assign permitted = q.lock_rep || (op == OPC_CHIP_ERASE) || (op == OPC_READ_STATUS) ||
    (op == OPC_IDENTITY_READ);

  // small parts fall back to all pages for unsupported codes
  assign size_code = (SMALL_FLASH && q.lock[3:1] != SIZE_ALL && q.lock[3:1] != SIZE_NONE) ?
    SIZE_ALL : q.lock[3:1];
  assign wr_addr = {1'b0, flash_wr_addr_in};
  assign ahb_sel = hsel_in & htrans_in[1] & hready_in;

  // next state
  always_comb begin
    d = q;
    d.cmd_valid = 1'b0;

    // three-stage pin synchronisers, change taken when stages 2 and 3 agree
    d.clk_sync = {q.clk_sync[1:0], dbg_clock_pin_in};
    d.dat_sync = {q.dat_sync[1:0], dbg_data_pin_in};
    d.rst_sync = {q.rst_sync[1:0], chip_reset_pin_n_in};
    if (clk_stable) begin
      d.clk_f = q.clk_sync[2];
    end
    if (q.dat_sync[1] == q.dat_sync[2]) begin
      d.dat_f = q.dat_sync[2];
    end
    if (q.rst_sync[1] == q.rst_sync[2]) begin
      d.rst_f = q.rst_sync[2];
    end

    // debug entry: count clock rises while chip reset is held low
    if (!q.debug_mode) begin
      if (q.rst_f) begin
        d.entry_cnt = 2'd0;
      end else if (clk_rise && 32'(q.entry_cnt) < ENTRY_EDGES) begin
        d.entry_cnt = q.entry_cnt + 2'd1;
      end else if (clk_fall && 32'(q.entry_cnt) == ENTRY_EDGES) begin
        // enter on the fall after the second rise, so that fall is no data bit
        d.debug_mode = 1'b1;
      end
    end

    // reported lock copies the lock byte debug bit after a reset_n_in reset, not a chip reset pin reset
    if (q.refresh_pend) begin
      d.refresh_pend = 1'b0;
      d.lock_rep = q.lock[LOCK_DBG_BIT];
    end

    // erase countdown
    if (q.erase_busy) begin
      if (q.erase_cnt == 32'h0) begin
        d.erase_busy = 1'b0;
      end else begin
        d.erase_cnt = q.erase_cnt - 32'h1;
      end
    end

    // link engine, active only in debug mode
    if (q.debug_mode) begin
      case (q.link)
        LS_RX: begin
          d.data_pin.oe = 1'b0;
          if (clk_fall) begin // host drove on rise, sample on fall
            d.rx_shift = rx_byte;
            d.bit_cnt = q.bit_cnt + 4'h1;
            if (q.bit_cnt == BITS_PER_BYTE - 4'h1) begin
              d.bit_cnt = 4'h0;
              if (q.byte_idx == 2'd0) begin
                d.cmd.opcode = rx_byte;
                d.cmd.data = 24'h0;
              end else begin
                d.cmd.data = {q.cmd.data[15:0], rx_byte};
              end
              if (q.byte_idx == cmd_last_idx(op)) begin // 1 to 4 host bytes
                d.byte_idx = 2'd0;
                d.link = LS_TX;
                d.tx_from_core = 1'b0;
                d.tx_shift = status_byte;
                if (is_refresh(op)) begin
                  d.lock_rep = q.lock[LOCK_DBG_BIT];
                end
                if (permitted) begin
                  if (op == OPC_CHIP_ERASE) begin
                    d.lock = LOCK_ERASED; // all ones: unlocked, unprotected
                    d.erase_busy = 1'b1;
                    d.erase_cnt = ERASE_LAST;
                  end else if (op == OPC_WR_CONFIG) begin
                    d.cfg = rx_byte;
                  end else if (op == OPC_RD_CONFIG) begin
                    d.tx_shift = q.cfg;
                  end else if (op == OPC_IDENTITY_READ) begin
                    d.tx_shift = IDENT_BYTE;
                  end else if (op != OPC_READ_STATUS) begin
                    d.cmd_valid = 1'b1;
                    d.tx_from_core = 1'b1;
                  end
                end
              end else begin
                d.byte_idx = q.byte_idx + 2'd1;
              end
            end
          end
        end
        LS_TX: begin
          if (clk_rise && q.bit_cnt != BITS_PER_BYTE) begin // drive on rise
            d.data_pin.oe = 1'b1;
            d.bit_cnt = q.bit_cnt + 4'h1;
            if (q.tx_from_core && q.bit_cnt == 4'h0) begin
              d.data_pin.o = core_resp_in[7];
              d.tx_shift = {core_resp_in[6:0], 1'b0};
            end else begin
              d.data_pin.o = q.tx_shift[7]; // msb first
              d.tx_shift = {q.tx_shift[6:0], 1'b0};
            end
          end else if (clk_fall && q.bit_cnt == BITS_PER_BYTE) begin
            d.data_pin.oe = 1'b0; // host has sampled the last bit
            d.bit_cnt = 4'h0;
            d.link = LS_RX;
          end
        end
        default: begin
          d.link = LS_RX;
        end
      endcase
      d.clock_pin.oe = 1'b0; // clock pin is input only
      d.clock_pin.o = 1'b0;
    end else begin
      // outside debug mode the pins serve general i/o
      d.data_pin = gpio_data_pin_in;
      d.clock_pin = gpio_clock_pin_in;
    end

    // write protection of the addressed flash byte
    d.protected_q = 1'b0;
    if (wr_addr >= FLASH_TOP - tdpl_size_bytes(size_code)) begin
      d.protected_q = 1'b1; // region below top of flash
    end
    if (wr_addr <= PAGE0_LAST &&
        (!q.lock[LOCK_BOOT_BIT] || size_code == SIZE_ALL)) begin
      d.protected_q = 1'b1; // boot page lock
    end

    // ahb data phase: register writes
    d.ahb_wr = 1'b0;
    if (q.ahb_wr) begin
      if (q.ahb_addr == REG_CONFIG) begin
        d.cfg = hwdata_in[7:0];
      end else if (q.ahb_addr == REG_LOCK && q.cfg[CFG_INFO_PAGE_BIT] && !d.erase_busy) begin
        // flash programming clears bits only; main page selected means no effect
        d.lock = q.lock & hwdata_in[7:0];
      end
    end

    // ahb address phase: capture writes, prepare read data
    if (ahb_sel) begin
      d.ahb_wr = hwrite_in;
      d.ahb_addr = haddr_in[7:0];
      if (!hwrite_in) begin
        d.rdata = 32'h0; // read data stands until the next read
        case (haddr_in[7:0])
          REG_LOCK: d.rdata = {24'h0, q.lock}; // lock byte at info page location 0
          REG_CONFIG: d.rdata = {24'h0, q.cfg};
          REG_STATUS: begin
            d.rdata[RS_DEBUG_MODE] = q.debug_mode;
            d.rdata[RS_ERASE_BUSY] = q.erase_busy;
            d.rdata[RS_LOCK_REP] = q.lock_rep;
            d.rdata[RS_INFO_SEL] = q.cfg[CFG_INFO_PAGE_BIT];
          end
          default: d.rdata = 32'h0;
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q <= '0;
      q.clk_sync <= 3'h0;
      q.rst_sync <= 3'h7;
      q.rst_f <= 1'b1;
      q.link <= LS_RX;
      q.lock <= LOCK_ERASED;
      q.refresh_pend <= 1'b1;
      q.cfg <= CFG_RESET;
    end else begin
      q <= d;
    end
  end

  // outputs
  assign dbg_data_pin_out = q.data_pin.o;
  assign dbg_data_pin_oe_out = q.data_pin.oe;
  assign dbg_clock_pin_out = q.clock_pin.o;
  assign dbg_clock_pin_oe_out = q.clock_pin.oe;
  assign debug_mode_out = q.debug_mode;
  assign core_cmd_valid_out = q.cmd_valid;
  assign core_cmd_out = q.cmd;
  assign flash_wr_protected_out = q.protected_q;
  assign hrdata_out = q.rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

endmodule // tdpl_debug_port
`default_nettype wire

// file: sim/tdpl_debug_port_properties.sv
`default_nettype none
module tdpl_debug_port_properties import tdpl_pkg::*; (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic chip_reset_pin_n_in,
  input wire logic dbg_clock_pin_in,
  input wire logic dbg_data_pin_out,
  input wire logic dbg_data_pin_oe_out,
  input wire logic dbg_clock_pin_oe_out,
  input wire tdpl_pin_t gpio_data_pin_in,
  input wire logic debug_mode_out,
  input wire logic core_cmd_valid_out,
  input wire logic hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic up_q;
  // high once the previous edge also lay outside reset
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      up_q <= 1'b0;
    end else begin
      up_q <= 1'b1;
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_bus_okay: assert property (hreadyout_out && !hresp_out)
    else $error("bus slave stalled or erred");
  a_mode_sticky: assert property (debug_mode_out |=> debug_mode_out)
    else $error("debug mode left without reset");
  a_mode_entry: assert property ($rose(debug_mode_out) |-> !$past(chip_reset_pin_n_in, 2))
    else $error("debug mode entered without device reset held");
  a_clock_input: assert property (up_q && debug_mode_out && $past(debug_mode_out) |-> !dbg_clock_pin_oe_out)
    else $error("clock pin driven in debug mode");
  a_gpio_pass: assert property (up_q && !debug_mode_out && !$past(debug_mode_out)
    |-> {dbg_data_pin_out, dbg_data_pin_oe_out} == $past(gpio_data_pin_in))
    else $error("data pin not general purpose outside debug");
  a_drive_on_rise: assert property (debug_mode_out && dbg_data_pin_oe_out && $changed(dbg_data_pin_out)
    |-> $past(dbg_clock_pin_in, 2))
    else $error("reply bit changed away from clock rise");
  a_oe_on_rise: assert property ($rose(dbg_data_pin_oe_out) && $past(debug_mode_out, 4)
    |-> $past(dbg_clock_pin_in, 2))
    else $error("reply drive began away from clock rise");
  a_oe_release: assert property ($fell(dbg_data_pin_oe_out) && $past(debug_mode_out, 4)
    |-> !$past(dbg_clock_pin_in, 2))
    else $error("reply drive ended away from clock low");
  a_cmd_pulse: assert property (core_cmd_valid_out |-> debug_mode_out ##1 !core_cmd_valid_out)
    else $error("command strobe longer than a cycle");
  a_rdata_hold: assert property (up_q && !$past(hsel_in && htrans_in[1] && !hwrite_in && hready_in)
    |-> $stable(hrdata_out))
    else $error("read data changed without a read");
  c_entry: cover property ($rose(debug_mode_out));
  c_reply: cover property ($rose(dbg_data_pin_oe_out) && debug_mode_out);
  c_cmd: cover property (core_cmd_valid_out);
endmodule // tdpl_debug_port_properties
`default_nettype wire

// file: sim/tdpl_host_model.sv
`default_nettype none
module tdpl_host_model (
  input wire logic dev_o_in,
  input wire logic dev_oe_in,
  output logic clk_out,
  output logic rst_n_out,
  output logic lvl_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ho = 1'b0;
  logic hoe = 1'b0;
  logic last = 1'b0;
  initial begin
    clk_out = 1'b0;
    rst_n_out = 1'b1;
  end
  // remember the last driven level; an undriven line shows its inverse
  always @(dev_o_in or dev_oe_in or ho or hoe) begin
    if (dev_oe_in) begin
      last = dev_o_in;
    end else if (hoe) begin
      last = ho;
    end
  end
  assign lvl_out = dev_oe_in ? dev_o_in : (hoe ? ho : !last);
  // one link period: data set with the rise, line sampled at the fall
  task automatic pulse(output logic s);
    clk_out = 1'b1;
    #40;
    clk_out = 1'b0;
    s = lvl_out;
    #40;
  endtask
  // two clock rises while device reset is held low
  task automatic enter();
    logic s;
    rst_n_out = 1'b0;
    #100;
    repeat (2) pulse(s);
    rst_n_out = 1'b1;
    #200;
  endtask
  // fast system clock and no deep power mode are assumed throughout
  // host bytes msb first, then the line is released for the reply byte
  task automatic cmd(input logic [31:0] w, input int n, output logic [7:0] r);
    logic s;
    #1;
    hoe = 1'b1;
    for (int i = 0; i < 8 * n; i++) begin
      ho = w[31 - i];
      pulse(s);
    end
    hoe = 1'b0;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      pulse(s);
      r = {r[6:0], s};
    end
    #200;
  endtask
endmodule // tdpl_host_model
`default_nettype wire

// file: sim/tdpl_debug_port_bench.sv
`default_nettype none
module tdpl_debug_port_bench import tdpl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  tdpl_pin_t gp_d = '0;
  tdpl_pin_t gp_c = '0;
  logic [7:0] resp = 8'h00;
  logic [14:0] faddr = 15'h0;
  logic dclk, crst_n, dlvl, d_o, d_oe, mode, cvld, prot, hrdy, hrsp;
  logic [31:0] hrdata, r, res, ccmd;
  logic [7:0] b;
  logic [14:0] a;
  logic [63:0] q[$];
  logic [63:0] ent;
  event got;
  int miscompares = 0;
  int num_checks = 0;
  int cmds = 0;
  integer seed = 32'h23c6;
  int kb[8] = '{32, 24, 16, 8, 4, 2, 1, 0};
  tdpl_debug_port #(.ERASE_CYCLES(16)) i_tdpl_debug_port (.core_clk_in(clk), .reset_n_in(rst_n),
    .chip_reset_pin_n_in(crst_n), .dbg_clock_pin_in(dclk), .dbg_data_pin_in(dlvl),
    .dbg_data_pin_out(d_o), .dbg_data_pin_oe_out(d_oe), .dbg_clock_pin_out(),
    .dbg_clock_pin_oe_out(), .gpio_data_pin_in(gp_d), .gpio_clock_pin_in(gp_c),
    .debug_mode_out(mode), .core_cmd_valid_out(cvld), .core_cmd_out(ccmd), .core_resp_in(resp),
    .flash_wr_addr_in(faddr), .flash_wr_protected_out(prot), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hrdy),
    .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hrsp));
  tdpl_host_model i_tdpl_host_model (.dev_o_in(d_o), .dev_oe_in(d_oe), .clk_out(dclk),
    .rst_n_out(crst_n), .lvl_out(dlvl));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // random general purpose drive and forwarded-command strobe count
  always @(posedge clk) begin
    {gp_d, gp_c} <= 4'($random(seed));
    if (cvld === 1'b1) cmds++;
  end
  task automatic final_report();
    if (miscompares == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // expectation noted, then the result handed to the watcher
  task automatic cmp(input logic [31:0] v, input logic [31:0] e, input logic [31:0] m);
    q.push_back({m, e});
    res = v;
    -> got;
    wait (q.size() == 0); // watcher has taken this note before the next one
  endtask
  // compares each result that appears with the oldest note
  initial forever begin
    @(got);
    ent = q.pop_front();
    num_checks++;
    if ((res & ent[63:32]) !== ent[31:0]) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, res & ent[63:32], ent[31:0]);
    end
  end
  // single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ad};
    hwrite <= w;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  task automatic lk(input logic [31:0] w);
    i_tdpl_host_model.cmd(w, 1, b);
  endtask
  task automatic pq(input logic [14:0] ad, input logic e);
    @(posedge clk);
    faddr <= ad;
    repeat (2) @(posedge clk);
    cmp({31'h0, prot}, {31'h0, e}, 32'h1);
  endtask
  // mass erase, then status polled over the bus only
  task automatic erase();
    lk({OPC_CHIP_ERASE, 24'h0});
    r = 32'h2;
    while (r[RS_ERASE_BUSY] !== 1'b0) bus(1'b0, REG_STATUS, 32'h0);
  endtask
  initial begin
    #200us;
    miscompares++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b1, REG_LOCK, 32'h0);
    bus(1'b0, REG_LOCK, 32'h0); cmp(r, 32'hff, '1);
    bus(1'b0, 8'h0c, 32'h0); cmp(r, 32'h0, '1);
    i_tdpl_host_model.enter();
    cmp({31'h0, mode}, 32'h1, '1);
    lk({OPC_READ_STATUS, 24'h0}); cmp({24'h0, b}, 32'h4, 32'h4);
    for (int c = 0; c < 8; c++) begin
      erase();
      bus(1'b0, REG_LOCK, 32'h0); cmp(r, 32'hff, '1);
      bus(1'b1, REG_CONFIG, 32'h1);
      bus(1'b1, REG_LOCK, {24'h0, 4'h1, 3'(c), 1'b1});
      bus(1'b0, REG_LOCK, 32'h0); cmp(r, {24'h0, 4'h1, 3'(c), 1'b1}, '1);
      pq(15'h7fff, c != 7);
      pq(15'h0000, c == 0);
      a = 15'(32768 - kb[c] * 1024);
      if (c > 0 && c < 7) pq(a, 1'b1);
      if (c > 0 && c < 7) pq(a - 15'h1, 1'b0);
      a = 15'($random(seed));
      pq(a, 32'(a) >= 32768 - kb[c] * 1024);
    end
    bus(1'b1, REG_LOCK, 32'h1e);
    lk({OPC_READ_STATUS, 24'h0}); cmp({24'h0, b}, 32'h4, 32'h4);
    @(posedge clk);
    resp <= 8'($random(seed));
    lk({OPC_HALT, 24'h0}); cmp({24'h0, b}, {24'h0, resp}, 32'hff);
    cmp(32'(cmds), 32'h1, '1);
    cmp(ccmd, {OPC_HALT, 24'h0}, '1);
    lk({OPC_READ_STATUS, 24'h0}); cmp({24'h0, b}, 32'h0, 32'h4);
    lk({OPC_HALT, 24'h0}); cmp({24'h0, b}, 32'h0, 32'h4);
    cmp(32'(cmds), 32'h1, '1);
    erase();
    lk({OPC_READ_STATUS, 24'h0}); cmp({24'h0, b}, 32'h0, 32'h4);
    lk({OPC_HALT, 24'h0});
    lk({OPC_READ_STATUS, 24'h0}); cmp({24'h0, b}, 32'h4, 32'h4);
    bus(1'b1, REG_CONFIG, 32'h1);
    bus(1'b1, REG_LOCK, 32'h0f);
    pq(15'h0000, 1'b1);
    pq(15'h03ff, 1'b1);
    pq(15'h0400, 1'b0);
    final_report();
  end
endmodule // tdpl_debug_port_bench
bind tdpl_debug_port tdpl_debug_port_properties i_props (.core_clk_in(core_clk_in),
  .reset_n_in(reset_n_in), .chip_reset_pin_n_in(chip_reset_pin_n_in),
  .dbg_clock_pin_in(dbg_clock_pin_in), .dbg_data_pin_out(dbg_data_pin_out),
  .dbg_data_pin_oe_out(dbg_data_pin_oe_out), .dbg_clock_pin_oe_out(dbg_clock_pin_oe_out),
  .gpio_data_pin_in(gpio_data_pin_in), .debug_mode_out(debug_mode_out),
  .core_cmd_valid_out(core_cmd_valid_out), .hsel_in(hsel_in), .htrans_in(htrans_in),
  .hwrite_in(hwrite_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out));
`default_nettype wire
